// ==== hdl/xcs_pkg.sv ====
// Constants, register map and types shared by the call supervision block.
package xcs_pkg;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ           = 25_000_000;
	localparam int MS_PER_S         = 1000;
	localparam int MS_TICK_CYC      = CLK_HZ / MS_PER_S;
	localparam int SELECT_WAIT_S    = 3;
	localparam int POST_SELECT_S    = 20;
	localparam int SHORT_READY_S    = 2;
	localparam int LONG_READY_S     = 60;
	localparam int INCOMING_READY_S = 2;
	localparam int CLEAR_WAIT_S     = 2;
	localparam logic [15:0] SELECT_WAIT_MS    = 16'(SELECT_WAIT_S * MS_PER_S);
	localparam logic [15:0] POST_SELECT_MS    = 16'(POST_SELECT_S * MS_PER_S);
	localparam logic [15:0] SHORT_READY_MS    = 16'(SHORT_READY_S * MS_PER_S);
	localparam logic [15:0] LONG_READY_MS     = 16'(LONG_READY_S * MS_PER_S);
	localparam logic [15:0] INCOMING_READY_MS = 16'(INCOMING_READY_S * MS_PER_S);
	localparam logic [15:0] CLEAR_WAIT_MS     = 16'(CLEAR_WAIT_S * MS_PER_S);
	// ----------------------------------------------------------------
	// Register map and modifier byte layout
	// ----------------------------------------------------------------
	localparam logic [11:0] ADDR_STATUS   = 12'h000;
	localparam logic [11:0] ADDR_MASK     = 12'h004;
	localparam logic [11:0] ADDR_PROGRESS = 12'h008;
	localparam logic [11:0] ADDR_PHASE    = 12'h00c;
	localparam int BIT_SELECT_WAIT = 2;
	localparam int BIT_POST_SELECT = 3;
	localparam int BIT_CLEAR_WAIT  = 4;
	localparam int BIT_READY_WAIT  = 5;
	localparam int BIT_INCOMING    = 6;
	localparam logic [7:0] MODIFIER_USED = 8'h7c;
	localparam logic [7:0] MASK_RESET    = 8'h00;
	// ----------------------------------------------------------------
	// Keys and progress classes
	// ----------------------------------------------------------------
	localparam logic [3:0] KEY_DIAL   = 4'h0;
	localparam logic [3:0] KEY_DIRECT = 4'h1;
	localparam logic [3:0] KEY_DISC   = 4'h2;
	localparam logic [3:0] KEY_LOCAL  = 4'h3;
	localparam logic [3:0] KEY_COMM   = 4'h4;
	localparam logic [3:0] KEY_CLEAR  = 4'h5;
	localparam logic [3:0] CLS_WAIT     = 4'h0;
	localparam logic [3:0] CLS_CALLED   = 4'h1;
	localparam logic [3:0] CLS_REDIRECT = 4'h2;
	localparam logic [3:0] CLS_CONNFREE = 4'h3;
	localparam logic [3:0] CLS_BUSY     = 4'h4;
	localparam logic [3:0] CLS_ACCESS   = 4'h5;
	localparam logic [3:0] CLS_SERVICE  = 4'h6;
	localparam logic [3:0] CLS_CONGEST  = 4'h7;
	localparam logic [3:0] CLS_AGENCY   = 4'h8;
	localparam logic [3:0] CLS_REGISTER = 4'h9;
	localparam logic [3:0] CLS_UNKNOWN  = 4'hf;
	typedef enum logic [6:0] {
		PH_IDLE     = 7'h01,
		PH_SELWAIT  = 7'h02,
		PH_POSTSEL  = 7'h04,
		PH_SHORTRDY = 7'h08,
		PH_LONGRDY  = 7'h10,
		PH_INCRDY   = 7'h20,
		PH_CLRWAIT  = 7'h40
	} xcs_phase_e;
endpackage : xcs_pkg

// ==== hdl/xcs_call_supervision.sv ====
// Call supervision for a switched X.21 line: progress codes, call timers and keys.
`timescale 1ns/100ps
module xcs_call_supervision #(
	parameter int MS_TICK = xcs_pkg::MS_TICK_CYC
) (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        callRequest,
	input  wire logic        proceedToSelect,
	input  wire logic        selectionSent,
	input  wire logic        readyForData,
	input  wire logic        clearIssued,
	input  wire logic        dceReady,
	input  wire logic        callAccepted,
	input  wire logic        progressValid,
	input  wire logic [3:0]  progressHigh,
	input  wire logic [3:0]  progressLow,
	input  wire logic        callReady,
	input  wire logic        dialInMode,
	input  wire logic        dialOrigin,
	input  wire logic        keyValid,
	input  wire logic [3:0]  keyCode,
	output logic             startClearing,
	output logic             eraseDialArea,
	output logic             clearScreen,
	output logic [7:0]       modifierByte,
	output logic [3:0]       progressClass,
	output logic             irq
);
	import xcs_pkg::*;

	// ----------------------------------------------------------------
	// Progress code classification
	// ----------------------------------------------------------------
	function automatic logic [3:0] classify(input logic [3:0] hi, input logic [3:0] lo);
		logic [3:0] c;
		c = CLS_UNKNOWN;
		unique case (hi)
			4'h0: c = (lo == 4'h0) ? CLS_WAIT : (lo == 4'h1) ? CLS_CALLED :
				(lo == 4'h2) ? CLS_REDIRECT : (lo == 4'h3) ? CLS_CONNFREE : CLS_UNKNOWN;
			4'h2: c = (lo <= 4'h3) ? CLS_BUSY : CLS_UNKNOWN;
			4'h4: c = (lo >= 4'h1 && lo <= 4'h9) ? CLS_ACCESS : CLS_UNKNOWN;
			4'h5: c = (lo == 4'h1 || lo == 4'h2) ? CLS_SERVICE : CLS_UNKNOWN;
			4'h6: c = (lo == 4'h1) ? CLS_CONGEST : CLS_UNKNOWN;
			4'h7: c = (lo == 4'h1) ? CLS_CONGEST : (lo == 4'h2) ? CLS_AGENCY : CLS_UNKNOWN;
			4'h8: c = (lo == 4'h1) ? CLS_REGISTER : CLS_UNKNOWN;
			default: c = CLS_UNKNOWN;
		endcase
		return c;
	endfunction : classify

	logic        progWait;
	logic        progRetry;
	logic [7:0]  progressCode;
	logic        progressPending;
	xcs_phase_e  phase;
	xcs_phase_e  next_phase;
	logic [15:0] msCnt;
	logic [15:0] elapsed;
	logic [15:0] limit;
	logic        tick;
	logic        expire;
	logic [7:0]  setBits;
	logic [7:0]  status;
	logic [7:0]  mask;
	logic        pendClear;

	assign progWait  = progressValid && (progressHigh == 4'h0);
	assign progRetry = progressValid && (progressHigh == 4'h2 || progressHigh == 4'h6);

	// ----------------------------------------------------------------
	// Progress capture
	// ----------------------------------------------------------------
	// The network never repeats the code, so the strobe is the only chance to catch it.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			progressCode  <= 8'h00;
			progressClass <= CLS_UNKNOWN;
		end else if (progressValid) begin
			progressCode  <= {progressHigh, progressLow};
			progressClass <= classify(progressHigh, progressLow);
		end
	end

	assign pendClear = callReady && progressPending && keyValid &&
		(keyCode == KEY_DIRECT || keyCode == KEY_DISC || keyCode == KEY_COMM);

	// A fresh code in the same cycle as a clearing key wins.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			progressPending <= 1'b0;
		end else if (progressValid) begin
			progressPending <= 1'b1;
		end else if (pendClear) begin
			progressPending <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Call phase timers
	// ----------------------------------------------------------------
	always_comb begin
		unique case (phase)
			PH_SELWAIT:  limit = SELECT_WAIT_MS;
			PH_POSTSEL:  limit = POST_SELECT_MS;
			PH_SHORTRDY: limit = SHORT_READY_MS;
			PH_LONGRDY:  limit = LONG_READY_MS;
			PH_INCRDY:   limit = INCOMING_READY_MS;
			PH_CLRWAIT:  limit = CLEAR_WAIT_MS;
			default:     limit = 16'hffff;
		endcase
	end

	assign tick   = (msCnt == 16'(MS_TICK - 1));
	assign expire = (phase != PH_IDLE) && (elapsed == limit);

	// Both counters restart on every phase change so each wait is measured from its cause.
	always_ff @(posedge sys_clk) begin
		if (!reset_n || next_phase != phase) begin
			msCnt   <= 16'h0000;
			elapsed <= 16'h0000;
		end else if (tick) begin
			msCnt   <= 16'h0000;
			elapsed <= elapsed + 16'h0001;
		end else begin
			msCnt   <= msCnt + 16'h0001;
		end
	end

	always_comb begin
		next_phase = phase;
		setBits    = 8'h00;
		unique case (phase)
			PH_IDLE: begin
				if (callRequest) next_phase = PH_SELWAIT;
				else if (selectionSent) next_phase = PH_POSTSEL;
				else if (callAccepted) next_phase = PH_INCRDY;
			end
			PH_SELWAIT: begin
				if (selectionSent) next_phase = PH_POSTSEL;
				else if (proceedToSelect) next_phase = PH_IDLE;
				else if (expire) begin
					next_phase = PH_IDLE;
					setBits[BIT_SELECT_WAIT] = 1'b1;
				end
			end
			PH_POSTSEL, PH_SHORTRDY: begin
				if (readyForData || progRetry) next_phase = PH_IDLE;
				else if (progWait) next_phase = PH_LONGRDY;
				else if (progressValid) next_phase = PH_SHORTRDY;
				else if (expire) begin
					next_phase = PH_IDLE;
					if (phase == PH_POSTSEL) setBits[BIT_POST_SELECT] = 1'b1;
					else setBits[BIT_READY_WAIT] = 1'b1;
				end
			end
			PH_LONGRDY: begin
				if (readyForData || progRetry) next_phase = PH_IDLE;
				else if (expire) begin
					next_phase = PH_IDLE;
					setBits[BIT_READY_WAIT] = 1'b1;
				end
			end
			PH_INCRDY: begin
				if (readyForData) next_phase = PH_IDLE;
				else if (expire) begin
					next_phase = PH_IDLE;
					setBits[BIT_INCOMING] = 1'b1;
				end
			end
			PH_CLRWAIT: begin
				if (dceReady) next_phase = PH_IDLE;
				else if (expire) begin
					next_phase = PH_IDLE;
					setBits[BIT_CLEAR_WAIT] = 1'b1;
				end
			end
			default: next_phase = PH_IDLE;
		endcase
		if (clearIssued) next_phase = PH_CLRWAIT;
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) phase <= PH_IDLE;
		else phase <= next_phase;
	end

	// ----------------------------------------------------------------
	// Key reactions and clearing request
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			startClearing <= 1'b0;
			eraseDialArea <= 1'b0;
			clearScreen   <= 1'b0;
		end else begin
			startClearing <= progRetry;
			eraseDialArea <= keyValid && keyCode == KEY_CLEAR && dialInMode && dialOrigin;
			clearScreen   <= keyValid && keyCode == KEY_CLEAR && !(dialInMode && dialOrigin);
		end
	end

	// ----------------------------------------------------------------
	// Registers over APB
	// ----------------------------------------------------------------
	logic wrAcc;
	logic mapped;
	assign wrAcc   = psel && penable && pwrite;
	assign mapped  = paddr == ADDR_STATUS || paddr == ADDR_MASK ||
		paddr == ADDR_PROGRESS || paddr == ADDR_PHASE;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !mapped;

	// A timer event landing with a write-one-to-clear survives it.
	always_ff @(posedge sys_clk) begin
		if (!reset_n) begin
			status <= 8'h00;
		end else begin
			status <= ((wrAcc && paddr == ADDR_STATUS) ? status & ~pwdata[7:0] : status)
				| (setBits & MODIFIER_USED);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!reset_n) mask <= MASK_RESET;
		else if (wrAcc && paddr == ADDR_MASK) mask <= pwdata[7:0] & MODIFIER_USED;
	end

	always_comb begin
		unique case (paddr)
			ADDR_STATUS:   prdata = {24'h000000, status};
			ADDR_MASK:     prdata = {24'h000000, mask};
			ADDR_PROGRESS: prdata = {19'h00000, progressPending, progressClass, progressCode};
			ADDR_PHASE:    prdata = {25'h0000000, phase};
			default:       prdata = 32'h00000000;
		endcase
	end

	assign modifierByte = status;
	assign irq          = |(status & mask);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	sequence s_retry_code;
		progressValid && (progressHigh == 4'h2 || progressHigh == 4'h6);
	endsequence

	AST_CAPTURE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		progressValid |=> progressPending && progressCode == $past({progressHigh, progressLow}))
		else $error("Progress code not captured.");
	AST_CLASS_BUSY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		progressValid && progressHigh == 4'h2 && progressLow == 4'h1 |=> progressClass == CLS_BUSY)
		else $error("Busy code misclassified.");
	AST_SELECT_EXPIRE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		phase == PH_SELWAIT && expire && !clearIssued && !selectionSent && !proceedToSelect
		|=> status[BIT_SELECT_WAIT] && phase == PH_IDLE)
		else $error("Select wait expiry not reported.");
	AST_POSTSEL_LIMIT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		phase == PH_POSTSEL |-> elapsed <= POST_SELECT_MS)
		else $error("Post selection wait overran.");
	AST_CLEAR_EXPIRE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		phase == PH_CLRWAIT && expire && !dceReady && !clearIssued |=> status[BIT_CLEAR_WAIT])
		else $error("Clear wait expiry not reported.");
	AST_SHORT_ENTRY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		phase == PH_POSTSEL && progressValid && progressHigh == 4'h4 && !clearIssued
		&& !readyForData |=> phase == PH_SHORTRDY)
		else $error("Short ready wait not started.");
	AST_LONG_ENTRY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		phase == PH_POSTSEL && progWait && !clearIssued && !readyForData
		|=> phase == PH_LONGRDY && limit == LONG_READY_MS)
		else $error("Long ready wait not selected.");
	AST_INCOMING_EXPIRE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		phase == PH_INCRDY && expire && !readyForData && !clearIssued |=> status[BIT_INCOMING])
		else $error("Incoming ready expiry not reported.");
	AST_KEY_CLEARS: assert property (@(posedge sys_clk) disable iff (!reset_n)
		pendClear && !progressValid |=> !progressPending)
		else $error("Pending progress not cleared by key.");
	AST_CLEAR_KEY: assert property (@(posedge sys_clk) disable iff (!reset_n)
		keyValid && keyCode == KEY_CLEAR |=> eraseDialArea != clearScreen)
		else $error("CLEAR key reaction wrong.");
	AST_RETRY_CLEAR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_retry_code |=> startClearing ##1 !startClearing || $past(progRetry))
		else $error("Retry code did not start clearing.");
	AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
		(modifierByte & ~MODIFIER_USED) == 8'h00)
		else $error("Reserved modifier bit set.");
endmodule : xcs_call_supervision

// ==== verification/xcs_net_model.sv ====
// Behavioural model of the network terminating equipment on the switched line.
`timescale 1ns/100ps
module xcs_net_model (
	input  wire logic       sys_clk,
	output logic            proceedToSelect,
	output logic            readyForData,
	output logic            dceReady,
	output logic            progressValid,
	output logic [3:0]      progressHigh,
	output logic [3:0]      progressLow
);
	initial begin
		proceedToSelect = 1'b0;
		readyForData = 1'b0;
		dceReady = 1'b0;
		progressValid = 1'b0;
		progressHigh = 4'h0;
		progressLow = 4'h0;
	end
	// ----------------------------------------------------------------
	// State changes: 0 proceed to select, 1 ready for data, 2 ready.
	// ----------------------------------------------------------------
	task signal_state(input int which);
		@(posedge sys_clk);
		proceedToSelect <= (which == 0);
		readyForData <= (which == 1);
		dceReady <= (which == 2);
		@(posedge sys_clk);
		proceedToSelect <= 1'b0;
		readyForData <= 1'b0;
		dceReady <= 1'b0;
	endtask : signal_state
	// ----------------------------------------------------------------
	// Progress code
	// ----------------------------------------------------------------
	// The code is sent once; afterwards the digits carry junk, so a late capture fails.
	task send_code(input logic [3:0] hi, input logic [3:0] lo);
		@(posedge sys_clk);
		progressValid <= 1'b1;
		progressHigh <= hi;
		progressLow <= lo;
		@(posedge sys_clk);
		progressValid <= 1'b0;
		progressHigh <= ~hi;
		progressLow <= ~lo;
	endtask : send_code
endmodule : xcs_net_model

// ==== verification/tb_xcs_call_supervision.sv ====
// Self-checking testbench for the call supervision block.
`timescale 1ns/100ps
module tb_xcs_call_supervision;
	import xcs_pkg::*;
	localparam int TICK = 1;
	localparam logic [7:0] CODES [18] = '{8'h24, 8'h50, 8'h04, 8'h00, 8'h01, 8'h02, 8'h03,
		8'h20, 8'h23, 8'h41, 8'h45, 8'h49, 8'h51, 8'h52, 8'h61, 8'h71, 8'h72, 8'h81};
	localparam logic [3:0] CLS [18] = '{4'hf, 4'hf, 4'hf, 4'h0, 4'h1, 4'h2, 4'h3,
		4'h4, 4'h4, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h9};
	localparam logic [3:0] KEYS [3] = '{KEY_DIRECT, KEY_DISC, KEY_COMM};
	logic        sys_clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, callRequest = 1'b0, selectionSent = 1'b0;
	logic        clearIssued = 1'b0, callAccepted = 1'b0, callReady = 1'b0, keyValid = 1'b0;
	logic        dialInMode = 1'b0, dialOrigin = 1'b0, proceedToSelect, readyForData, dceReady;
	logic        progressValid, startClearing, eraseDialArea, clearScreen, irq;
	logic [3:0]  keyCode = 4'h0, progressHigh, progressLow, progressClass;
	logic [7:0]  modifierByte;
	int          errTotal = 0, numChecks = 0;
	always #20 sys_clk = ~sys_clk;
	xcs_call_supervision #(.MS_TICK(TICK)) u_dut (.sys_clk(sys_clk), .reset_n(reset_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .callRequest(callRequest),
		.proceedToSelect(proceedToSelect), .selectionSent(selectionSent),
		.readyForData(readyForData), .clearIssued(clearIssued), .dceReady(dceReady),
		.callAccepted(callAccepted), .progressValid(progressValid),
		.progressHigh(progressHigh), .progressLow(progressLow), .callReady(callReady),
		.dialInMode(dialInMode), .dialOrigin(dialOrigin), .keyValid(keyValid),
		.keyCode(keyCode), .startClearing(startClearing), .eraseDialArea(eraseDialArea),
		.clearScreen(clearScreen), .modifierByte(modifierByte),
		.progressClass(progressClass), .irq(irq));
	xcs_net_model u_net (.sys_clk(sys_clk), .proceedToSelect(proceedToSelect),
		.readyForData(readyForData), .dceReady(dceReady), .progressValid(progressValid),
		.progressHigh(progressHigh), .progressLow(progressLow));
	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wrap_up;
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : wrap_up
	// The master never counts cycles; only the watchdog guards against a dead slave.
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	// Event pulse: 0 call request, 1 selection sent, 2 clear issued, 3 call accepted.
	task ev(input int k);
		@(posedge sys_clk);
		callRequest <= (k == 0);
		selectionSent <= (k == 1);
		clearIssued <= (k == 2);
		callAccepted <= (k == 3);
		@(posedge sys_clk);
		callRequest <= 1'b0;
		selectionSent <= 1'b0;
		clearIssued <= 1'b0;
		callAccepted <= 1'b0;
	endtask : ev
	task key(input logic [3:0] c);
		@(posedge sys_clk);
		keyValid <= 1'b1;
		keyCode <= c;
		@(posedge sys_clk);
		keyValid <= 1'b0;
		keyCode <= ~c;
	endtask : key
	task expire(input int ms, input int b);
		int n;
		n = 0;
		repeat (ms * TICK - 8) @(posedge sys_clk);
		#1 chk(modifierByte[b], 1'b0);
		while (modifierByte[b] !== 1'b1 && n < 20) begin
			@(posedge sys_clk);
			#1 n++;
		end
		chk(modifierByte[b], 1'b1);
		rdchk(ADDR_PHASE, 32'h01);
	endtask : expire
	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		#1 chk({irq, progressClass, modifierByte}, 13'h0f00);
		rdchk(ADDR_PHASE, 32'h01);
		rdchk(ADDR_MASK, 32'h0);
		rdchk(12'h010, 32'h0);
		chk(err, 1'b1);
		$display("test reset done");
		for (int i = 0; i < 18; i++) begin
			u_net.send_code(CODES[i][7:4], CODES[i][3:0]);
			#1 chk(progressClass, CLS[i]);
			chk(startClearing, CODES[i][7:4] == 4'h2 || CODES[i][7:4] == 4'h6);
		end
		rdchk(ADDR_PROGRESS, 32'h1981);
		$display("test decode done");
		key(KEY_DIRECT);
		rdchk(ADDR_PROGRESS, 32'h1981);
		@(posedge sys_clk) callReady <= 1'b1;
		key(KEY_LOCAL);
		rdchk(ADDR_PROGRESS, 32'h1981);
		for (int k = 0; k < 3; k++) begin
			key(KEYS[k]);
			apb(1'b0, ADDR_PROGRESS, 32'h0);
			chk(rd[12], 1'b0);
			u_net.send_code(4'h8, 4'h1);
		end
		@(posedge sys_clk) dialInMode <= 1'b1;
		for (int o = 1; o >= 0; o--) begin
			@(posedge sys_clk) dialOrigin <= o[0];
			key(KEY_CLEAR);
			#1 chk({eraseDialArea, clearScreen}, {o[0], ~o[0]});
		end
		$display("test keys done");
		apb(1'b1, ADDR_MASK, 32'h7c);
		ev(0);
		rdchk(ADDR_PHASE, 32'h02);
		expire(SELECT_WAIT_MS, BIT_SELECT_WAIT);
		#1 chk(irq, 1'b1);
		apb(1'b1, ADDR_MASK, 32'h0);
		#1 chk(irq, 1'b0);
		apb(1'b1, ADDR_MASK, 32'h7c);
		#1 chk(irq, 1'b1);
		apb(1'b1, ADDR_STATUS, 32'h04);
		#1 chk({irq, modifierByte}, 9'h000);
		ev(0);
		u_net.signal_state(0);
		rdchk(ADDR_PHASE, 32'h01);
		ev(0);
		ev(1);
		rdchk(ADDR_PHASE, 32'h04);
		expire(POST_SELECT_MS, BIT_POST_SELECT);
		$display("test select timers done");
		ev(1);
		u_net.send_code(4'h0, 4'h0);
		rdchk(ADDR_PHASE, 32'h10);
		repeat (2100) @(posedge sys_clk);
		rdchk(ADDR_PHASE, 32'h10);
		chk(modifierByte[BIT_READY_WAIT], 1'b0);
		u_net.signal_state(1);
		rdchk(ADDR_PHASE, 32'h01);
		ev(1);
		u_net.send_code(4'h4, 4'h1);
		rdchk(ADDR_PHASE, 32'h08);
		expire(SHORT_READY_MS, BIT_READY_WAIT);
		ev(1);
		u_net.send_code(4'h2, 4'h1);
		#1 chk(startClearing, 1'b1);
		rdchk(ADDR_PHASE, 32'h01);
		ev(3);
		rdchk(ADDR_PHASE, 32'h20);
		expire(INCOMING_READY_MS, BIT_INCOMING);
		ev(2);
		rdchk(ADDR_PHASE, 32'h40);
		expire(CLEAR_WAIT_MS, BIT_CLEAR_WAIT);
		ev(2);
		u_net.signal_state(2);
		rdchk(ADDR_PHASE, 32'h01);
		apb(1'b1, ADDR_STATUS, 32'h83);
		rdchk(ADDR_STATUS, 32'h78);
		#1 chk({irq, modifierByte}, 9'h178);
		$display("test ready timers done");
		wrap_up();
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		errTotal++;
		wrap_up();
	end
endmodule : tb_xcs_call_supervision
